// File: design/cssc_pkg.sv
package cssc_pkg;
   // ****************************************
   // Geometry
   // ****************************************
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int BE_W = 4;
   localparam int RAM_ADDR_W = 13;
   localparam int OFS_LO = 2;
   localparam int OFS_HI = 13;
   localparam int DM_BIT = 14;
   localparam int LINES = 8192;
   localparam int LINE_W = 13;
   localparam int TAGS = 1024;
   localparam int TAG_IDX_W = 10;
   // Tag keeps A14 so two-way lines that differ only in A14 never alias
   localparam int TAG_W = 18;
   localparam int TAG_LO = 14;
   localparam int SETS = 512;
   localparam int SET_W = 9;
   localparam int SET_LO = 5;
   localparam int WAY_LINE_LO = 2;
   localparam logic [BE_W-1:0] BE_NONE = 4'hf;
   typedef enum logic {CSSC_DIRECT, CSSC_TWO_WAY} cssc_mode_e;
endpackage

// File: design/cssc_directory.sv
module cssc_directory
   import cssc_pkg::*;
#(
   parameter int LINES_P = cssc_pkg::LINES,
   parameter int TAGS_P = cssc_pkg::TAGS,
   parameter int SETS_P = cssc_pkg::SETS
) (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic [cssc_pkg::ADDR_W-1:0] i_lookup_addr,
   input wire logic i_two_way,
   input wire logic i_fill,
   input wire logic [cssc_pkg::ADDR_W-1:0] i_fill_addr,
   input wire logic i_invalidate,
   input wire logic i_flush,
   output logic o_hit,
   output logic o_hit_way_b
);
   import cssc_pkg::*;

   if (LINES_P != 2 ** LINE_W || TAGS_P != 2 ** TAG_IDX_W || SETS_P != 2 ** SET_W) begin : geometry_check
      $error("cssc_directory: geometry not supported");
   end

   // ****************************************
   // Tag directory storage
   // ****************************************
   logic [TAG_W-1:0] tag_q [TAGS_P];
   logic [TAG_W-1:0] tag_d [TAGS_P];
   logic [LINES_P-1:0] valid_q;
   logic [LINES_P-1:0] valid_d;
   logic [SETS_P-1:0] lru_q;
   logic [SETS_P-1:0] lru_d;

   // Line index: direct uses A14..A2; two way uses way bit on top of A13..A2
   function automatic logic [LINE_W-1:0] line_of(input logic [ADDR_W-1:0] a, input logic way_b,
                                                input logic tw);
      line_of = tw ? {way_b, a[OFS_HI:OFS_LO]} : a[DM_BIT:OFS_LO];
   endfunction

   function automatic logic [TAG_IDX_W-1:0] tag_of(input logic [ADDR_W-1:0] a, input logic way_b,
                                                  input logic tw);
      logic [LINE_W-1:0] l;
      l = line_of(a, way_b, tw);
      tag_of = l[LINE_W-1:LINE_W-TAG_IDX_W];
   endfunction

   logic hit_a;
   logic hit_b;
   always_comb begin
      hit_a = valid_q[line_of(i_lookup_addr, 1'b0, i_two_way)] &&
              tag_q[tag_of(i_lookup_addr, 1'b0, i_two_way)] == i_lookup_addr[ADDR_W-1:TAG_LO];
      hit_b = i_two_way && valid_q[line_of(i_lookup_addr, 1'b1, i_two_way)] &&
              tag_q[tag_of(i_lookup_addr, 1'b1, i_two_way)] == i_lookup_addr[ADDR_W-1:TAG_LO];
      o_hit = hit_a || hit_b;
      o_hit_way_b = hit_b;
   end

   logic fill_way;
   always_comb begin
      valid_d = valid_q;
      tag_d = tag_q;
      lru_d = lru_q;
      fill_way = i_two_way && lru_q[i_fill_addr[SET_LO+SET_W-1:SET_LO]];
      if (i_fill) begin
         valid_d[line_of(i_fill_addr, fill_way, i_two_way)] = 1'b1;
         tag_d[tag_of(i_fill_addr, fill_way, i_two_way)] = i_fill_addr[ADDR_W-1:TAG_LO];
         lru_d[i_fill_addr[SET_LO+SET_W-1:SET_LO]] = ~fill_way;
      end
      if (i_invalidate && hit_a) begin
         valid_d[line_of(i_lookup_addr, 1'b0, i_two_way)] = 1'b0;
      end
      if (i_invalidate && hit_b) begin
         valid_d[line_of(i_lookup_addr, 1'b1, i_two_way)] = 1'b0;
      end
      if (i_flush) begin
         valid_d = '0;
      end
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         valid_q <= '0;
         lru_q <= '0;
         for (int i = 0; i < TAGS_P; i++) begin
            tag_q[i] <= '0;
         end
      end else begin
         valid_q <= valid_d;
         lru_q <= lru_d;
         tag_q <= tag_d;
      end
   end
endmodule

// File: design/cssc_controller.sv
// Contract
// - Capture posted write, finish without wait while the post slot is idle.
// - Write memory after system bus grant.
// - Master mode answers hold request with grant.
// - Directory lookup muxes processor and watch address.
// - External write hit clears valid bit.
// - Watch strobe latches system address.
// - Flush clears every valid bit in the directory.
// - Two way: 32-bit data, A13..A2 address.
// - Separate read/write enables per bank.
// - Drive transceiver direction and address latch.
// - Four active-low byte lane selects.
// - Direct mode mirrors bank A, adds A14.
// - Read enable asserts with write strobe.
// - Read hit: bank read enable and ready together.
// - Directory holds 1024 tags, 8192 valids, 512 LRU.
module cssc_controller
   import cssc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_two_way,
   input wire logic i_master_mode,
   input wire logic i_cpu_start,
   input wire logic i_cpu_write,
   input wire logic [cssc_pkg::ADDR_W-1:0] i_cpu_addr,
   input wire logic [cssc_pkg::DATA_W-1:0] i_cpu_wdata,
   input wire logic [cssc_pkg::BE_W-1:0] i_cpu_be_n,
   input wire logic [3:0] i_cpu_cycle_type,
   output logic o_cpu_ready,
   output logic o_cpu_miss,
   input wire logic i_fill,
   output logic [cssc_pkg::RAM_ADDR_W-1:0] o_ram_addr,
   output logic [cssc_pkg::DATA_W-1:0] o_ram_wdata,
   output logic o_ram_wdata_oe,
   output logic o_bank_a_read_enable_n,
   output logic o_bank_b_read_enable_n,
   output logic o_bank_a_write_strobe_n,
   output logic o_bank_b_write_strobe_n,
   output logic o_transceiver_direction,
   output logic o_ram_addr_latch_enable,
   output logic [cssc_pkg::BE_W-1:0] o_byte_lane_select_n,
   output logic o_sys_request,
   input wire logic i_sys_grant,
   input wire logic i_sys_done,
   output logic [cssc_pkg::ADDR_W-1:0] o_sys_addr,
   output logic [cssc_pkg::DATA_W-1:0] o_sys_wdata,
   output logic [cssc_pkg::BE_W-1:0] o_sys_be_n,
   output logic [3:0] o_sys_cycle_type,
   input wire logic i_sysbus_hold_request,
   output logic o_sysbus_hold_grant,
   input wire logic i_watch_enable,
   input wire logic i_watch_strobe,
   input wire logic [cssc_pkg::ADDR_W-1:0] i_watch_addr,
   input wire logic i_flush
);
   import cssc_pkg::*;

   typedef enum logic [1:0] {CSSC_IDLE, CSSC_READ, CSSC_WRITE} cssc_cpu_e;
   typedef enum logic [1:0] {CSSC_POST_IDLE, CSSC_POST_REQ, CSSC_POST_BUSY} cssc_post_e;

   // ****************************************
   // State
   // ****************************************
   cssc_cpu_e cpu_q, cpu_d;
   cssc_post_e post_q, post_d;
   logic [ADDR_W-1:0] cpu_addr_q, cpu_addr_d;
   logic [DATA_W-1:0] wdata_q, wdata_d;
   logic [BE_W-1:0] be_n_q, be_n_d;
   logic [3:0] type_q, type_d;
   logic [ADDR_W-1:0] post_addr_q, post_addr_d;
   logic [DATA_W-1:0] post_data_q, post_data_d;
   logic [BE_W-1:0] post_be_q, post_be_d;
   logic [3:0] post_type_q, post_type_d;
   logic [ADDR_W-1:0] watch_addr_q, watch_addr_d;
   logic watch_pend_q, watch_pend_d;
   logic grant_q, grant_d;
   logic ready_q, ready_d;
   logic miss_q, miss_d;
   logic rd_a_q, rd_a_d, rd_b_q, rd_b_d, wr_a_q, wr_a_d, wr_b_q, wr_b_d;
   logic [BE_W-1:0] sel_q, sel_d;

   logic lookup_watch;
   logic [ADDR_W-1:0] lookup_addr;
   logic hit;
   logic hit_b;

   // ****************************************
   // Directory
   // ****************************************
   // Watch lookups take the directory when no processor cycle needs it
   assign lookup_watch = watch_pend_q && cpu_q == CSSC_IDLE;
   assign lookup_addr = lookup_watch ? watch_addr_q : cpu_addr_q;

   cssc_directory u_directory (
      .i_clock(i_clock),
      .i_reset_n(i_reset_n),
      .i_lookup_addr(lookup_addr),
      .i_two_way(i_two_way),
      .i_fill(i_fill && cpu_q == CSSC_IDLE && !lookup_watch),
      .i_fill_addr(cpu_addr_q),
      .i_invalidate(lookup_watch),
      .i_flush(i_flush),
      .o_hit(hit),
      .o_hit_way_b(hit_b)
   );

   // ****************************************
   // Processor, posting and watch logic
   // ****************************************
   always_comb begin
      cpu_d = cpu_q;
      post_d = post_q;
      cpu_addr_d = cpu_addr_q;
      wdata_d = wdata_q;
      be_n_d = be_n_q;
      type_d = type_q;
      post_addr_d = post_addr_q;
      post_data_d = post_data_q;
      post_be_d = post_be_q;
      post_type_d = post_type_q;
      watch_addr_d = watch_addr_q;
      watch_pend_d = watch_pend_q && !lookup_watch;
      ready_d = 1'b0;
      miss_d = 1'b0;
      rd_a_d = 1'b0;
      rd_b_d = 1'b0;
      wr_a_d = 1'b0;
      wr_b_d = 1'b0;
      sel_d = BE_NONE;
      // Hold grant follows the request in master mode and drops one clock after it
      grant_d = i_master_mode && i_sysbus_hold_request;
      if (i_watch_enable && i_watch_strobe) begin
         watch_addr_d = i_watch_addr;
         watch_pend_d = 1'b1;
      end
      unique case (cpu_q)
         CSSC_IDLE: begin
            if (i_cpu_start) begin
               cpu_addr_d = i_cpu_addr;
               wdata_d = i_cpu_wdata;
               be_n_d = i_cpu_be_n;
               type_d = i_cpu_cycle_type;
               cpu_d = i_cpu_write ? CSSC_WRITE : CSSC_READ;
            end
         end
         CSSC_READ: begin
            cpu_d = CSSC_IDLE;
            if (hit) begin
               rd_a_d = !hit_b || !i_two_way;
               rd_b_d = hit_b || !i_two_way;
               sel_d = '0;
               ready_d = 1'b1;
            end else begin
               miss_d = 1'b1;
            end
         end
         CSSC_WRITE: begin
            // Write is held only while the single post slot is busy
            if (post_q == CSSC_POST_IDLE) begin
               cpu_d = CSSC_IDLE;
               post_addr_d = cpu_addr_q;
               post_data_d = wdata_q;
               post_be_d = be_n_q;
               post_type_d = type_q;
               post_d = CSSC_POST_REQ;
               ready_d = 1'b1;
               if (hit) begin
                  wr_a_d = !hit_b || !i_two_way;
                  wr_b_d = hit_b || !i_two_way;
                  rd_a_d = !hit_b || !i_two_way;
                  rd_b_d = hit_b || !i_two_way;
                  sel_d = be_n_q;
               end
            end
         end
         default: cpu_d = CSSC_IDLE;
      endcase
      unique case (post_q)
         CSSC_POST_IDLE: ;
         CSSC_POST_REQ: begin
            if (i_sys_grant && !grant_q) begin
               post_d = CSSC_POST_BUSY;
            end
         end
         CSSC_POST_BUSY: begin
            if (i_sys_done) begin
               post_d = CSSC_POST_IDLE;
            end
         end
         default: post_d = CSSC_POST_IDLE;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         cpu_q <= CSSC_IDLE;
         post_q <= CSSC_POST_IDLE;
         cpu_addr_q <= '0;
         wdata_q <= '0;
         be_n_q <= BE_NONE;
         type_q <= '0;
         post_addr_q <= '0;
         post_data_q <= '0;
         post_be_q <= BE_NONE;
         post_type_q <= '0;
         watch_addr_q <= '0;
         watch_pend_q <= 1'b0;
         grant_q <= 1'b0;
         ready_q <= 1'b0;
         miss_q <= 1'b0;
         rd_a_q <= 1'b0;
         rd_b_q <= 1'b0;
         wr_a_q <= 1'b0;
         wr_b_q <= 1'b0;
         sel_q <= BE_NONE;
      end else begin
         cpu_q <= cpu_d;
         post_q <= post_d;
         cpu_addr_q <= cpu_addr_d;
         wdata_q <= wdata_d;
         be_n_q <= be_n_d;
         type_q <= type_d;
         post_addr_q <= post_addr_d;
         post_data_q <= post_data_d;
         post_be_q <= post_be_d;
         post_type_q <= post_type_d;
         watch_addr_q <= watch_addr_d;
         watch_pend_q <= watch_pend_d;
         grant_q <= grant_d;
         ready_q <= ready_d;
         miss_q <= miss_d;
         rd_a_q <= rd_a_d;
         rd_b_q <= rd_b_d;
         wr_a_q <= wr_a_d;
         wr_b_q <= wr_b_d;
         sel_q <= sel_d;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign o_cpu_ready = ready_q;
   assign o_cpu_miss = miss_q;
   assign o_sysbus_hold_grant = grant_q;
   assign o_sys_request = post_q != CSSC_POST_IDLE;
   assign o_sys_addr = post_addr_q;
   assign o_sys_wdata = post_data_q;
   assign o_sys_be_n = post_be_q;
   assign o_sys_cycle_type = post_type_q;
   // Direct mode adds A14 on top of A13..A2
   assign o_ram_addr = {cpu_addr_q[DM_BIT] & ~i_two_way, cpu_addr_q[OFS_HI:OFS_LO]};
   assign o_ram_wdata = wdata_q;
   assign o_ram_wdata_oe = wr_a_q | wr_b_q;
   assign o_bank_a_read_enable_n = ~rd_a_q;
   assign o_bank_b_read_enable_n = ~rd_b_q;
   assign o_bank_a_write_strobe_n = ~wr_a_q;
   assign o_bank_b_write_strobe_n = ~wr_b_q;
   assign o_transceiver_direction = wr_a_q | wr_b_q;
   assign o_ram_addr_latch_enable = cpu_q == CSSC_IDLE;
   assign o_byte_lane_select_n = sel_q;
endmodule

// File: verif/cssc_sysbus_model.sv
module cssc_sysbus_model (
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_sys_request,
   input wire logic i_hold_busy,
   input wire logic i_slow,
   output logic o_sys_grant,
   output logic o_sys_done
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] wait_q, wait_d;
   logic grant_d, done_d;
   // ****************************************
   // Arbiter and memory
   // ****************************************
   // Stops granting one clock after another master takes the bus
   always_comb begin
      wait_d = (i_sys_request && !i_hold_busy) ? wait_q + {3'h0, wait_q != 4'hf} : 4'h0;
      grant_d = i_sys_request && !i_hold_busy && wait_q >= (i_slow ? 4'h6 : 4'h0);
      done_d = grant_d && wait_q == (i_slow ? 4'h9 : 4'h2);
   end
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         wait_q <= 4'h0;
         o_sys_grant <= 1'b0;
         o_sys_done <= 1'b0;
      end else begin
         wait_q <= wait_d;
         o_sys_grant <= grant_d;
         o_sys_done <= done_d;
      end
   end
endmodule

module cssc_ram_model
   import cssc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic [cssc_pkg::RAM_ADDR_W-1:0] i_ram_addr,
   input wire logic [cssc_pkg::DATA_W-1:0] i_ram_wdata,
   input wire logic i_read_enable_n,
   input wire logic i_write_strobe_n,
   input wire logic [cssc_pkg::BE_W-1:0] i_byte_lane_select_n,
   output logic [cssc_pkg::DATA_W-1:0] o_ram_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   // ****************************************
   // Cache data store
   // ****************************************
   // One bank of 8K words with latched address and byte lanes
   logic [DATA_W-1:0] mem_q [LINES];
   // Read data stays driven while the write strobe is also low
   assign o_ram_rdata = i_read_enable_n ? '0 : mem_q[i_ram_addr];
   always_ff @(posedge i_clock or negedge i_reset_n) begin
      if (!i_reset_n) begin
         for (int i = 0; i < LINES; i++) begin
            mem_q[i] <= '0;
         end
      end else if (!i_write_strobe_n) begin
         for (int b = 0; b < BE_W; b++) begin
            if (!i_byte_lane_select_n[b]) begin
               mem_q[i_ram_addr][8 * b +: 8] <= i_ram_wdata[8 * b +: 8];
            end
         end
      end
   end
endmodule

// File: verif/cssc_controller_monitor.sv
module cssc_controller_monitor
   import cssc_pkg::*;
(
   input wire logic i_clock,
   input wire logic i_reset_n,
   input wire logic i_two_way,
   input wire logic i_master_mode,
   input wire logic i_cpu_start,
   input wire logic i_cpu_write,
   input wire logic i_sys_done,
   input wire logic i_sysbus_hold_request,
   input wire logic o_cpu_ready,
   input wire logic o_cpu_miss,
   input wire logic o_bank_a_read_enable_n,
   input wire logic o_bank_b_read_enable_n,
   input wire logic o_bank_a_write_strobe_n,
   input wire logic o_bank_b_write_strobe_n,
   input wire logic o_transceiver_direction,
   input wire logic o_ram_addr_latch_enable,
   input wire logic [cssc_pkg::BE_W-1:0] o_byte_lane_select_n,
   input wire logic o_sys_request,
   input wire logic [cssc_pkg::ADDR_W-1:0] o_sys_addr,
   input wire logic o_sysbus_hold_grant
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge i_clock); endclocking
   default disable iff (!i_reset_n);
   // ****************************************
   // Checks
   // ****************************************
   read_answer_a:
      assert property (i_cpu_start && !i_cpu_write && o_ram_addr_latch_enable |=> !o_ram_addr_latch_enable ##1
         (o_cpu_miss || (o_cpu_ready && !(o_bank_a_read_enable_n && o_bank_b_read_enable_n)))) else $error("read");
   write_nowait_a:
      assert property (i_cpu_start && i_cpu_write && o_ram_addr_latch_enable && !o_sys_request |=> ##1 o_cpu_ready)
         else $error("write wait");
   latch_close_a:
      assert property (i_cpu_start && o_ram_addr_latch_enable |=> !o_ram_addr_latch_enable) else $error("latch");
   ready_pulse_a:
      assert property (o_cpu_ready |=> !o_cpu_ready) else $error("ready width");
   enable_pair_a:
      assert property (!o_bank_a_write_strobe_n |-> !o_bank_a_read_enable_n && o_transceiver_direction)
         else $error("enable pair");
   bank_mirror_a:
      assert property (!i_two_way |-> o_bank_b_read_enable_n == o_bank_a_read_enable_n &&
         o_bank_b_write_strobe_n == o_bank_a_write_strobe_n) else $error("mirror");
   hit_selects_a:
      assert property (o_cpu_ready && o_bank_a_write_strobe_n && o_bank_b_write_strobe_n && !o_bank_a_read_enable_n
         |-> o_byte_lane_select_n == 4'h0) else $error("selects");
   hold_grant_a:
      assert property (i_master_mode && i_sysbus_hold_request |=> o_sysbus_hold_grant) else $error("grant");
   hold_release_a:
      assert property (!i_sysbus_hold_request |=> !o_sysbus_hold_grant) else $error("release");
   post_keep_a:
      assert property (o_sys_request && !i_sys_done |=> o_sys_request && $stable(o_sys_addr)) else $error("post");
endmodule
bind cssc_controller cssc_controller_monitor cssc_controller_monitor_i (.*);

// File: verif/test_cache_sram_snoop_control.sv
module test_cache_sram_snoop_control;
   import cssc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [ADDR_W-1:0] ADR = 32'h0000_6abc;
   logic i_clock, i_reset_n, i_two_way, i_master_mode, i_cpu_start, i_cpu_write, i_fill, i_sys_grant, i_sys_done;
   logic i_sysbus_hold_request, i_watch_enable, i_watch_strobe, i_flush, bus_slow;
   logic [ADDR_W-1:0] i_cpu_addr, i_watch_addr, o_sys_addr;
   logic [DATA_W-1:0] i_cpu_wdata, o_ram_wdata, o_sys_wdata, ram_rdata, rd;
   logic [BE_W-1:0] i_cpu_be_n, o_byte_lane_select_n, o_sys_be_n;
   logic [3:0] i_cpu_cycle_type, o_sys_cycle_type;
   logic [RAM_ADDR_W-1:0] o_ram_addr, ra;
   logic o_cpu_ready, o_cpu_miss, o_ram_wdata_oe, o_bank_a_read_enable_n, o_bank_b_read_enable_n;
   logic o_bank_a_write_strobe_n, o_bank_b_write_strobe_n, o_transceiver_direction, o_ram_addr_latch_enable;
   logic o_sys_request, o_sysbus_hold_grant;
   logic [10:0] snap;
   int mismatches, checks_done, cycles, lat;
   cssc_controller cssc_controller_i (.*);
   cssc_sysbus_model cssc_sysbus_model_i (.i_clock, .i_reset_n, .i_sys_request(o_sys_request),
      .i_hold_busy(o_sysbus_hold_grant), .i_slow(bus_slow), .o_sys_grant(i_sys_grant), .o_sys_done(i_sys_done));
   cssc_ram_model cssc_ram_model_i (.i_clock, .i_reset_n, .i_ram_addr(o_ram_addr), .i_ram_wdata(o_ram_wdata),
      .i_read_enable_n(o_bank_a_read_enable_n), .i_write_strobe_n(o_bank_a_write_strobe_n),
      .i_byte_lane_select_n(o_byte_lane_select_n), .o_ram_rdata(ram_rdata));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic chk(input logic [95:0] got, input logic [95:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cpu(input logic wr, input logic [31:0] d, input logic [3:0] be);
      @(negedge i_clock);
      {i_cpu_start, i_cpu_write, i_cpu_addr, i_cpu_wdata, i_cpu_be_n, i_cpu_cycle_type} = {1'b1, wr, ADR, d, be, ~be};
      @(negedge i_clock);
      i_cpu_start = 1'b0;
      lat = 0;
      while (o_cpu_ready !== 1'b1 && o_cpu_miss !== 1'b1 && lat < 40) begin
         @(negedge i_clock);
         lat++;
      end
      ra = o_ram_addr;
      rd = ram_rdata;
      snap = {o_cpu_ready, o_cpu_miss, o_bank_b_read_enable_n, o_bank_a_read_enable_n, o_bank_b_write_strobe_n,
         o_bank_a_write_strobe_n, o_transceiver_direction, o_byte_lane_select_n};
   endtask
   task automatic pulse(ref logic s);
      @(negedge i_clock);
      s = 1'b1;
      @(negedge i_clock);
      s = 1'b0;
   endtask
   task automatic miss_fill_hit;
      cpu(1'b0, 32'h0, 4'h0);
      chk(snap[10:5], 6'h1f);
      pulse(i_fill);
      cpu(1'b0, 32'h0, 4'h0);
      chk(lat, 1);
   endtask
   task automatic snoop(input logic [31:0] a, input logic [1:0] exp);
      i_watch_addr = a;
      pulse(i_watch_strobe);
      repeat (3) @(negedge i_clock);
      cpu(1'b0, 32'h0, 4'h0);
      chk(snap[10:9], exp);
   endtask
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_direct_read;
      miss_fill_hit();
      chk(snap, 11'h460);
      chk(ra, {ADR[DM_BIT], ADR[OFS_HI:OFS_LO]});
      chk({o_ram_wdata_oe, rd}, 33'h0);
   endtask
   task automatic t_posted_write;
      cpu(1'b1, 32'h1234_5678, 4'ha);
      chk(lat, 1);
      chk(snap, 11'h41a);
      chk({o_ram_wdata_oe, o_ram_wdata}, {1'b1, 32'h1234_5678});
      chk({o_sys_request, o_sys_addr, o_sys_wdata, o_sys_be_n, o_sys_cycle_type}, {1'b1, ADR, 32'h1234_5678, 8'ha5});
      cpu(1'b0, 32'h0, 4'h0);
      chk({lat, o_sys_request}, {32'd1, 1'b1});
      chk(rd, 32'h0034_0078);
      cpu(1'b1, 32'hcafe_0001, 4'h0);
      chk(lat > 1, 1'b1);
      lat = 0;
      while (o_sys_request !== 1'b0 && lat < 40) begin
         @(negedge i_clock);
         lat++;
      end
      chk(o_sys_request, 1'b0);
   endtask
   task automatic t_hold;
      i_master_mode = 1'b1;
      i_sysbus_hold_request = 1'b1;
      repeat (6) @(negedge i_clock);
      chk(o_sysbus_hold_grant, 1'b1);
      i_sysbus_hold_request = 1'b0;
      @(negedge i_clock);
      chk(o_sysbus_hold_grant, 1'b0);
      i_master_mode = 1'b0;
      i_sysbus_hold_request = 1'b1;
      repeat (3) @(negedge i_clock);
      chk(o_sysbus_hold_grant, 1'b0);
      i_sysbus_hold_request = 1'b0;
   endtask
   task automatic t_watch_flush;
      i_watch_enable = 1'b1;
      snoop(ADR ^ 32'h0002_0000, 2'b10);
      snoop(ADR, 2'b01);
      i_watch_enable = 1'b0;
      miss_fill_hit();
      pulse(i_flush);
      cpu(1'b0, 32'h0, 4'h0);
      chk(snap[10:9], 2'b01);
   endtask
   task automatic t_two_way;
      i_two_way = 1'b1;
      miss_fill_hit();
      chk({snap[10:9], ^snap[8:7]}, 3'b101);
      chk(ra, {1'b0, ADR[OFS_HI:OFS_LO]});
   endtask
   task automatic report_and_stop;
      if (mismatches == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ****************************************
   // Run
   // ****************************************
   initial begin
      i_clock = 1'b0;
      forever #25 i_clock = ~i_clock;
   end
   always @(posedge i_clock) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         report_and_stop();
      end
   end
   initial begin
      {i_reset_n, i_two_way, i_master_mode, i_cpu_start, i_cpu_write, i_fill, i_sysbus_hold_request} = '0;
      {i_watch_enable, i_watch_strobe, i_flush, i_cpu_addr, i_watch_addr, i_cpu_wdata, i_cpu_be_n} = '0;
      i_cpu_cycle_type = 4'h0;
      bus_slow = 1'b1;
      repeat (4) @(posedge i_clock);
      @(negedge i_clock);
      i_reset_n = 1'b1;
      t_direct_read();
      t_posted_write();
      t_hold();
      t_watch_flush();
      t_two_way();
      report_and_stop();
   end
endmodule
